// ---- dv/monitor_port_master.sv ----
// read-only monitor port master model
`timescale 1ns/1ps
`default_nettype none
module monitor_port_master (
	output logic port_select_n,
	output logic monitor_port_clock,
	output logic monitor_port_mosi,
	input wire logic monitor_port_miso_o,
	input wire logic monitor_port_miso_oe_n
);
	// clock stands low between frames
	initial begin
		port_select_n = 1'b1;
		monitor_port_clock = 1'b0;
		monitor_port_mosi = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// always a whole 40-clock frame, a cut frame may corrupt data
	task automatic read_reg(input logic [7:0] addr, output logic [31:0] data);
		data = 32'h0;
		// keep pin changes clear of the system clock edges
		#5;
		port_select_n = 1'b0;
		#150;
		for (int i = 0; i < 40; i++) begin
			monitor_port_mosi = (i < 8) ? addr[7 - i] : ~monitor_port_mosi;
			#100;
			monitor_port_clock = 1'b1;
			if (i >= 8)
				data = {data[30:0], monitor_port_miso_oe_n ? 1'bx : monitor_port_miso_o};
			#100;
			monitor_port_clock = 1'b0;
		end
		#150;
		port_select_n = 1'b1;
		monitor_port_mosi = ~monitor_port_mosi; // released line shows no stale level
	endtask : read_reg
endmodule : monitor_port_master
`default_nettype wire

// ---- dv/supervisor_checker_properties.sv ----
// port-level assertions for the system supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic port_select_n,
	input wire logic monitor_port_miso_oe_n,
	input wire logic [3:0] rail_monitor,
	input wire logic [1:0] temp_overtemp,
	input wire logic rails_power_good,
	input wire logic supplies_enable,
	input wire logic controller_reset_n,
	input wire logic mirror_park_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// bus answer one cycle after taking, one cycle wide, data only with it
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too wide");
	data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	// power good follows the rail OR through the sync flops
	pg_low_a: assert property ((rail_monitor == 4'h0) [*5] |-> !rails_power_good)
		else $error("power good without rail");
	pg_high_a: assert property ((rail_monitor != 4'h0) [*5] |-> rails_power_good)
		else $error("power good missing");
	// serial pin driven only inside a frame
	port_idle_a: assert property (port_select_n [*5] |-> monitor_port_miso_oe_n)
		else $error("driving while deselected");
	port_busy_a: assert property ((!port_select_n) [*5] |-> !monitor_port_miso_oe_n)
		else $error("not driving in frame");
	// state outputs stay consistent with each other
	park_power_a: assert property (!mirror_park_n |-> supplies_enable && controller_reset_n)
		else $error("park without power");
	reset_power_a: assert property ($rose(controller_reset_n) |-> $past(supplies_enable, 1))
		else $error("reset released unpowered");
	overtemp_off_a: assert property ((temp_overtemp != 2'h0) [*8] |-> !supplies_enable)
		else $error("powered in overtemp");
endmodule : supervisor_checker
bind system_supervisor_monitor supervisor_checker chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .port_select_n(port_select_n), .monitor_port_miso_oe_n(monitor_port_miso_oe_n),
	.rail_monitor(rail_monitor), .temp_overtemp(temp_overtemp), .rails_power_good(rails_power_good),
	.supplies_enable(supplies_enable), .controller_reset_n(controller_reset_n), .mirror_park_n(mirror_park_n)
);
`default_nettype wire

// ---- dv/system_supervisor_monitor_tb.sv ----
// self-checking bench for the system supervisor
`timescale 1ns/1ps
`default_nettype none
module system_supervisor_monitor_tb;
	import supervisor_pkg::*;
	localparam int SEQ_HZ = 1_000_000;
	logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, system_on_request, main_input_supply_low;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, rail_monitor;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic port_select_n, monitor_port_clock, monitor_port_mosi, monitor_port_miso_o, monitor_port_miso_oe_n;
	logic [1:0] temp_warning, temp_overtemp, wdp;
	logic sequencer_clock_in, rails_power_good, supplies_enable, controller_reset_n, mirror_park_n, processor_alert;
	wire logic processor_watchdog_pulse = wdp[0];
	wire logic sequence_start_pulse = wdp[1];
	int n_mismatch = 0;
	int tests_run = 0;
	int k;
	system_supervisor_monitor dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .port_select_n(port_select_n), .monitor_port_clock(monitor_port_clock),
		.monitor_port_mosi(monitor_port_mosi), .monitor_port_miso_o(monitor_port_miso_o),
		.monitor_port_miso_oe_n(monitor_port_miso_oe_n), .system_on_request(system_on_request),
		.main_input_supply_low(main_input_supply_low), .rail_monitor(rail_monitor),
		.temp_warning(temp_warning), .temp_overtemp(temp_overtemp),
		.processor_watchdog_pulse(processor_watchdog_pulse), .sequence_start_pulse(sequence_start_pulse),
		.sequencer_clock_in(sequencer_clock_in), .rails_power_good(rails_power_good),
		.supplies_enable(supplies_enable), .controller_reset_n(controller_reset_n),
		.mirror_park_n(mirror_park_n), .processor_alert(processor_alert)
	);
	monitor_port_master mon_u (
		.port_select_n(port_select_n), .monitor_port_clock(monitor_port_clock),
		.monitor_port_mosi(monitor_port_mosi), .monitor_port_miso_o(monitor_port_miso_o),
		.monitor_port_miso_oe_n(monitor_port_miso_oe_n)
	);
	////////////////////////////////////////////////////////////////
	// 40 MHz clock; sequencer clock slow so sampling does not alias
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		sequencer_clock_in = 1'b0;
		forever #500 sequencer_clock_in = ~sequencer_clock_in;
	end
	function automatic logic pg_of(input logic [3:0] r);
		return |r;
	endfunction : pg_of
	function automatic logic [31:0] flag_of(input int w, input int late);
		return 32'h1 << (2 * w + (late ? FLAG_WD_LATE : FLAG_WD_EARLY));
	endfunction : flag_of
	function automatic logic [31:0] ratio_of();
		return 32'(SEQ_HZ * RATIO_GATE_TICKS / INT_OSC_HZ);
	endfunction : ratio_of
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// classic cycle held until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		chk(32'(n < 20), 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : wb
	task automatic wait_st(input sup_state_e s);
		wb(1'b0, ADDR_STATUS, 32'h0);
		for (int i = 0; i < 400 && q[2:0] !== s; i++)
			wb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[2:0], s);
	endtask : wait_st
	task automatic pulse(input int w, input int gap);
		wdp[w] <= 1'b1;
		cyc(4);
		wdp[w] <= 1'b0;
		cyc(gap - 4);
	endtask : pulse
	task automatic tend(input string s);
		$display("test %s done, %0d checks", s, tests_run);
	endtask : tend
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////
	// hang guard, well above the expected run length
	initial begin
		#2_000_000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		void'($urandom(32'hd1d6a63c));
		{wb_cyc_i, wb_stb_i, wb_we_i, system_on_request, main_input_supply_low} = '0;
		{temp_warning, temp_overtemp, wdp} = '0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		rail_monitor = 4'h0;
		rst_n = 1'b0;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		// identity is read-only, unmapped reads zero, window reads back on both ports
		wb(1'b0, ADDR_ID, 32'h0);
		chk(q, ID_VALUE);
		wb(1'b1, ADDR_ID, $urandom);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, ADDR_ID, 32'h0);
		chk(q, ID_VALUE);
		k = $urandom;
		wb(1'b1, ADDR_WD1_WIN, k);
		wb(1'b0, ADDR_WD1_WIN, 32'h0);
		chk(q, k);
		mon_u.read_reg(ADDR_WD1_WIN, q);
		chk(q, k);
		cyc(1);
		// partial byte lanes: only lanes 0 and 2 take the new value
		wb_sel_i <= 4'h5;
		wb(1'b1, ADDR_WD1_WIN, ~k);
		wb_sel_i <= 4'hf;
		wb(1'b0, ADDR_WD1_WIN, 32'h0);
		chk(q, (k & 32'hff00ff00) | (~k & 32'h00ff00ff));
		for (int i = 0; i < 6; i++) begin
			rail_monitor <= (i == 0) ? 4'h0 : 4'($urandom);
			cyc(6);
			chk(rails_power_good, pg_of(rail_monitor));
		end
		tend("regs");
		// early edge, clear, in-window edges, then silence past close
		for (int w = 0; w < 2; w++) begin
			wb(1'b1, ADDR_WD0_WIN + 8'(4 * w), {16'd8, 16'd4});
			wb(1'b1, ADDR_CTRL, 32'(1 << w));
			pulse(w, 20);
			pulse(w, 4);
			wb(1'b0, ADDR_FLAGS, 32'h0);
			chk(q, flag_of(w, 0));
			wb(1'b1, ADDR_FLAGS, 32'h3f);
			cyc(100);
			pulse(w, 120);
			pulse(w, 240);
			wb(1'b0, ADDR_FLAGS, 32'h0);
			chk(q, flag_of(w, 1));
			wb(1'b1, ADDR_FLAGS, 32'h3f);
		end
		tend("watchdog");
		// warning holds power-on back and raises the alert
		k = $urandom_range(1);
		wb(1'b1, ADDR_CTRL, 32'(1 << CTRL_ALERT_EN));
		temp_warning[k] <= 1'b1;
		rail_monitor <= 4'hf;
		system_on_request <= 1'b1;
		cyc(200);
		wb(1'b0, ADDR_STATUS, 32'h0);
		chk(q[2:0], ST_OFF);
		chk(processor_alert, 1'b1);
		wb(1'b0, ADDR_FLAGS, 32'h0);
		chk(q, 32'(1 << FLAG_WARN));
		temp_warning[k] <= 1'b0;
		wb(1'b1, ADDR_FLAGS, 32'h3f);
		cyc(4);
		chk(processor_alert, 1'b0);
		wait_st(ST_STANDBY);
		tend("power");
		// brownout parks then goes off
		main_input_supply_low <= 1'b1;
		for (k = 0; k < 20 && mirror_park_n !== 1'b0; k++)
			cyc(1);
		chk(mirror_park_n, 1'b0);
		wait_st(ST_OFF);
		main_input_supply_low <= 1'b0;
		wait_st(ST_STANDBY);
		// enabled watchdog error in standby powers down
		wb(1'b1, ADDR_WD1_WIN, {16'd8, 16'd4});
		wb(1'b1, ADDR_CTRL, 32'h2);
		pulse(1, 4);
		for (k = 0; k < 400 && controller_reset_n !== 1'b0; k++)
			cyc(1);
		chk(controller_reset_n, 1'b0);
		wb(1'b1, ADDR_CTRL, 32'h0);
		wait_st(ST_STANDBY);
		tend("brownout");
		// overtemp shuts down until the request goes low
		k = $urandom_range(1);
		temp_overtemp[k] <= 1'b1;
		wait_st(ST_SHUTDOWN);
		cyc(10);
		temp_overtemp[k] <= 1'b0;
		cyc(50);
		mon_u.read_reg(ADDR_STATUS, q);
		chk(q[2:0], ST_SHUTDOWN);
		cyc(1);
		wb(1'b0, ADDR_FLAGS, 32'h0);
		chk(q[FLAG_OVERTEMP], 1'b1);
		system_on_request <= 1'b0;
		wait_st(ST_OFF);
		wb(1'b0, ADDR_RATIO, 32'h0);
		chk(32'((q + 32'h1 - ratio_of()) <= 32'h2), 32'h1);
		tend("overtemp");
		// reset mid-run clears everything
		system_on_request <= 1'b1;
		wait_st(ST_STANDBY);
		rst_n <= 1'b0;
		cyc(2);
		chk(supplies_enable, 1'b0);
		rst_n <= 1'b1;
		cyc(1);
		wb(1'b0, ADDR_WD1_WIN, 32'h0);
		chk(q, WIN_RESET);
		tend("reset");
		end_sim();
	end
endmodule : system_supervisor_monitor_tb
`default_nettype wire

// ---- src/supervisor_pkg.sv ----
// shared constants, register map and state codes for the system supervisor
package supervisor_pkg;

	// clocking
	localparam int unsigned REF_CLK_PERIOD_PS = 25000;
	localparam int unsigned REF_CLK_HZ = 40_000_000;
	localparam int unsigned INT_OSC_HZ = 2_000_000;
	localparam int unsigned OSC_DIV = REF_CLK_HZ / INT_OSC_HZ;
	localparam logic [4:0] OSC_DIV_LAST = 5'(OSC_DIV - 1);

	// mirror park hold time, least time so rounded up
	localparam int unsigned PARK_TIME_NS = 10_000;
	localparam int unsigned PARK_CYCLES = (PARK_TIME_NS * 1000 + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam logic [11:0] PARK_LAST = 12'(PARK_CYCLES - 1);

	// clock ratio gate, in oscillator ticks
	localparam logic [7:0] RATIO_GATE_TICKS = 8'h40;

	// register byte offsets
	localparam logic [7:0] ADDR_ID = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_WD0_WIN = 8'h10;
	localparam logic [7:0] ADDR_WD1_WIN = 8'h14;
	localparam logic [7:0] ADDR_RATIO = 8'h18;

	// identity word, value arbitrary
	localparam logic [31:0] ID_VALUE = 32'h0000_5a01;

	// flag bit positions
	localparam int unsigned FLAG_WD_EARLY = 0; // +2*watchdog
	localparam int unsigned FLAG_WD_LATE = 1;  // +2*watchdog
	localparam int unsigned FLAG_WARN = 4;
	localparam int unsigned FLAG_OVERTEMP = 5;
	localparam int unsigned FLAG_W = 6;

	// control bit positions
	localparam int unsigned CTRL_WD_EN = 0; // bits 1:0
	localparam int unsigned CTRL_ALERT_EN = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [31:0] WIN_RESET = 32'h0000_0000;

	// synchroniser reset levels follow the pin idle levels; only the select pin idles high
	localparam logic [14:0] SYNC_IDLE = 15'h1000;

	// monitor port framing
	localparam logic [5:0] MON_ADDR_BITS = 6'h08;
	localparam logic [5:0] MON_FRAME_BITS = 6'h28;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_POWER_UP = 3'b001,
		ST_STANDBY = 3'b011,
		ST_PARKING = 3'b010,
		ST_SHUTDOWN = 3'b110
	} sup_state_e;

endpackage : supervisor_pkg

// ---- src/system_supervisor_monitor.sv ----
// supervisor: power state machine, two windowed watchdogs, temperature and clock monitors, register ports
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none

module system_supervisor_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	// wishbone classic slave, primary register port
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// monitor serial port pins
	input wire logic port_select_n,
	input wire logic monitor_port_clock,
	input wire logic monitor_port_mosi,
	output logic monitor_port_miso_o,
	output logic monitor_port_miso_oe_n,
	// system pins
	input wire logic system_on_request,
	input wire logic main_input_supply_low,
	input wire logic [3:0] rail_monitor,
	input wire logic [1:0] temp_warning,
	input wire logic [1:0] temp_overtemp,
	input wire logic processor_watchdog_pulse,
	input wire logic sequence_start_pulse,
	input wire logic sequencer_clock_in,
	output logic rails_power_good,
	output logic supplies_enable,
	output logic controller_reset_n,
	output logic mirror_park_n,
	output logic processor_alert
);
	import supervisor_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers: first stage feeds only the second

	localparam int unsigned NSYNC = 15;
	logic [NSYNC-1:0] pin_async;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic [NSYNC-1:0] sync3_reg;

	assign pin_async = {monitor_port_mosi, monitor_port_clock, port_select_n, sequencer_clock_in,
		sequence_start_pulse, processor_watchdog_pulse, temp_overtemp, temp_warning, rail_monitor,
		main_input_supply_low};

	// third stage only serves edge detection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
			sync3_reg <= SYNC_IDLE;
		end else begin
			sync1_reg <= pin_async;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	logic brownout;
	logic [3:0] rail_s;
	logic warn_any;
	logic overtemp_any;
	logic [1:0] wd_edge;
	logic sequencer_clock_in_edge;
	logic sel_n_s;
	logic mclk_rise;
	logic mclk_fall;
	logic mosi_s;
	logic on_req_s;
	logic on_sync1_reg;
	logic on_sync2_reg;

	assign brownout = sync2_reg[0];
	assign rail_s = sync2_reg[4:1];
	assign warn_any = |sync2_reg[6:5];
	assign overtemp_any = |sync2_reg[8:7];
	assign wd_edge = sync2_reg[10:9] & ~sync3_reg[10:9];
	assign sequencer_clock_in_edge = sync2_reg[11] & ~sync3_reg[11];
	assign sel_n_s = sync2_reg[12];
	assign mclk_rise = sync2_reg[13] & ~sync3_reg[13];
	assign mclk_fall = ~sync2_reg[13] & sync3_reg[13];
	assign mosi_s = sync2_reg[14];
	assign on_req_s = on_sync2_reg;

	// on request kept apart so its reset level is off
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_sync1_reg <= 1'b0;
			on_sync2_reg <= 1'b0;
		end else begin
			on_sync1_reg <= system_on_request;
			on_sync2_reg <= on_sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// internal oscillator tick, one pulse every OSC_DIV cycles

	logic [4:0] div_reg;
	logic osc_tick;
	assign osc_tick = (div_reg == OSC_DIV_LAST);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) div_reg <= '0;
		else div_reg <= osc_tick ? 5'h00 : div_reg + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers

	logic [2:0] ctrl_reg;
	logic [31:0] win_reg [2];
	logic [FLAG_W-1:0] flags_reg;
	logic [15:0] ratio_reg;
	sup_state_e state_reg;
	sup_state_e state_next;
	logic wb_req;
	logic wb_wr;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i;

	// shared read decode, unmapped offsets read zero
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			ADDR_ID: v = ID_VALUE;
			ADDR_STATUS: v = {20'h00000, overtemp_any, warn_any, brownout, on_req_s, rails_power_good,
				4'h0, state_reg};
			ADDR_FLAGS: v = {26'h0000000, flags_reg};
			ADDR_CTRL: v = {29'h00000000, ctrl_reg};
			ADDR_WD0_WIN: v = win_reg[0];
			ADDR_WD1_WIN: v = win_reg[1];
			ADDR_RATIO: v = {16'h0000, ratio_reg};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_read

	// byte-lane merge for writable words
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : lane_merge

	// ack comes one cycle after the request and drops the cycle after
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req & ~wb_we_i) ? reg_read(wb_adr_i) : 32'h0000_0000;
		end
	end

	// control and window writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
			win_reg[0] <= WIN_RESET;
			win_reg[1] <= WIN_RESET;
		end else if (wb_wr) begin
			if (wb_adr_i == ADDR_CTRL && wb_sel_i[0]) ctrl_reg <= wb_dat_i[2:0];
			if (wb_adr_i == ADDR_WD0_WIN) win_reg[0] <= lane_merge(win_reg[0], wb_dat_i, wb_sel_i);
			if (wb_adr_i == ADDR_WD1_WIN) win_reg[1] <= lane_merge(win_reg[1], wb_dat_i, wb_sel_i);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// windowed watchdogs, counting oscillator ticks; low half opens, high half closes

	logic [15:0] wd_cnt_reg [2];
	logic [1:0] wd_run_reg;
	logic [1:0] wd_early;
	logic [1:0] wd_late;

	for (genvar w = 0; w < 2; w++) begin : g_wd
		assign wd_early[w] = ctrl_reg[CTRL_WD_EN + w] & wd_edge[w] & wd_run_reg[w]
			& (wd_cnt_reg[w] < win_reg[w][15:0]);
		assign wd_late[w] = ctrl_reg[CTRL_WD_EN + w] & ~wd_edge[w] & wd_run_reg[w] & osc_tick
			& (wd_cnt_reg[w] >= win_reg[w][31:16]);

		// each watchdog keeps its own counter, nothing shared
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				wd_cnt_reg[w] <= '0;
				wd_run_reg[w] <= 1'b0;
			end else if (!ctrl_reg[CTRL_WD_EN + w]) begin
				wd_cnt_reg[w] <= '0;
				wd_run_reg[w] <= 1'b0;
			end else if (wd_edge[w]) begin
				wd_cnt_reg[w] <= '0;
				wd_run_reg[w] <= 1'b1;
			end else if (wd_late[w]) begin
				wd_run_reg[w] <= 1'b0; // stop after a late error until the next edge
			end else if (wd_run_reg[w] && osc_tick) begin
				wd_cnt_reg[w] <= wd_cnt_reg[w] + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky flags: write one to clear, a new event in the same cycle wins

	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_clr;
	logic warn_prev_reg;
	logic ot_prev_reg;

	assign flag_set = {overtemp_any & ~ot_prev_reg, warn_any & ~warn_prev_reg,
		wd_late[1], wd_early[1], wd_late[0], wd_early[0]};
	assign flag_clr = (wb_wr && wb_adr_i == ADDR_FLAGS && wb_sel_i[0]) ? wb_dat_i[FLAG_W-1:0] : '0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= '0;
			warn_prev_reg <= 1'b0;
			ot_prev_reg <= 1'b0;
		end else begin
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
			warn_prev_reg <= warn_any;
			ot_prev_reg <= overtemp_any;
		end
	end

	// warning alert to the processor, gated by software
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) processor_alert <= 1'b0;
		else processor_alert <= flags_reg[FLAG_WARN] & ctrl_reg[CTRL_ALERT_EN];
	end

	////////////////////////////////////////////////////////////////////////////
	// clock ratio: sequencer clock edges counted over a fixed gate of oscillator ticks
	// sampled at ref_clk, so a full-rate sequencer clock aliases; software sees the
	// count and judges it, a wrong-harmonic lock still shows as a changed value

	logic [7:0] gate_reg;
	logic [15:0] edge_cnt_reg;
	logic gate_end;
	assign gate_end = osc_tick & (gate_reg == RATIO_GATE_TICKS - 8'h01);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_reg <= '0;
			edge_cnt_reg <= '0;
			ratio_reg <= '0;
		end else begin
			if (osc_tick) gate_reg <= gate_end ? 8'h00 : gate_reg + 8'h01;
			if (gate_end) begin
				ratio_reg <= edge_cnt_reg + {15'h0000, sequencer_clock_in_edge};
				edge_cnt_reg <= '0;
			end else if (sequencer_clock_in_edge) begin
				edge_cnt_reg <= edge_cnt_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power state machine

	logic rails_or;
	logic wd_fault;
	logic [11:0] park_cnt_reg;
	assign rails_or = |rail_s;
	assign wd_fault = |(wd_early | wd_late); // only enabled watchdogs can raise these

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: begin
				if (on_req_s && !brownout && !warn_any) state_next = ST_POWER_UP;
			end
			ST_POWER_UP: begin
				if (overtemp_any) state_next = ST_SHUTDOWN;
				else if (brownout) state_next = ST_OFF;
				else if (rails_power_good && !warn_any) state_next = ST_STANDBY;
			end
			ST_STANDBY: begin
				if (overtemp_any) state_next = ST_SHUTDOWN;
				else if (brownout) state_next = ST_PARKING;
				else if (!on_req_s || wd_fault) state_next = ST_OFF;
			end
			ST_PARKING: begin
				if (park_cnt_reg == PARK_LAST) state_next = ST_OFF;
			end
			ST_SHUTDOWN: begin
				if (!on_req_s) state_next = ST_OFF;
			end
			default: state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_OFF;
			park_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			park_cnt_reg <= (state_reg == ST_PARKING) ? park_cnt_reg + 12'h001 : 12'h000;
		end
	end

	// registered system outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rails_power_good <= 1'b0;
			supplies_enable <= 1'b0;
			controller_reset_n <= 1'b0;
			mirror_park_n <= 1'b1;
		end else begin
			rails_power_good <= rails_or;
			supplies_enable <= (state_next == ST_POWER_UP) || (state_next == ST_STANDBY)
				|| (state_next == ST_PARKING);
			controller_reset_n <= (state_next == ST_STANDBY) || (state_next == ST_PARKING);
			mirror_park_n <= (state_next != ST_PARKING);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// monitor port: 8 address bits in, then 32 data bits out, msb first
	// every register is readable here; nothing on this port writes

	logic [5:0] mon_bit_reg;
	logic [7:0] mon_addr_reg;
	logic [31:0] mon_shift_reg;
	logic mon_load;
	assign mon_load = mclk_rise & (mon_bit_reg == MON_ADDR_BITS - 6'h01);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_bit_reg <= '0;
			mon_addr_reg <= '0;
			mon_shift_reg <= '0;
			monitor_port_miso_o <= 1'b0;
			monitor_port_miso_oe_n <= 1'b1;
		end else if (sel_n_s) begin
			mon_bit_reg <= '0; // frame ends on select high
			monitor_port_miso_oe_n <= 1'b1;
			monitor_port_miso_o <= 1'b0;
		end else begin
			monitor_port_miso_oe_n <= 1'b0;
			if (mclk_rise && mon_bit_reg != MON_FRAME_BITS) begin
				mon_bit_reg <= mon_bit_reg + 6'h01;
				if (mon_bit_reg < MON_ADDR_BITS) mon_addr_reg <= {mon_addr_reg[6:0], mosi_s};
			end
			if (mon_load) mon_shift_reg <= reg_read({mon_addr_reg[6:0], mosi_s});
			else if (mclk_fall && mon_bit_reg > MON_ADDR_BITS) mon_shift_reg <= {mon_shift_reg[30:0], 1'b0};
			// later falls shift in the same cycle, so the next bit is the one below the top
			if (mclk_fall && mon_bit_reg == MON_ADDR_BITS) monitor_port_miso_o <= mon_shift_reg[31];
			else if (mclk_fall && mon_bit_reg > MON_ADDR_BITS) monitor_port_miso_o <= mon_shift_reg[30];
		end
	end

endmodule : system_supervisor_monitor

`default_nettype wire
